// ---- cbbm_core.sv ----
// Operation
// (RQ1) Carry ops 1 clock; bit ops 2 clocks
// (RQ2) Carry jumps: 2 bytes, 2 or 3 clocks
// (RQ3) Bit jumps 3/4 clocks; JBC clears bit
// (RQ4) Short call 3 clocks, long call 4
// (RQ5) Both returns: one byte, 5 clocks
// (RQ6) Jumps: short 3, long 4, indirect 3
// (RQ7) Accumulator zero jumps: 2 or 3 clocks
// (RQ8) Compare jumps 3/4; indirect form 4/5
// (RQ9) Decrement jumps: register 2/3, direct 3/4
// (RQ10) No-op and spare opcode: one clock
// (RQ11) Relative offset signed, from next instruction
// (RQ12) Registers from active bank; pointers R0/R1
// (RQ13) Direct below 0x80 RAM, above special
// (RQ14) Absolute target stays in 2 kB page
// (RQ15) Long target is full 16 bits
// (RQ16) 64 KB space; above 0x3DFF reserved
// (RQ17) Store writes need program-store enable
// (RQ18) 256 bytes RAM; low half both modes
// (RQ19) Above 0x7F: direct special, indirect RAM
// (RQ20) Four banks selected by status bits 3,4
// (RQ21) Bit address = 8*offset + bit position
// (RQ22) Bit or byte decided by instruction kind
// (RQ23) Untaken branch short count, taken long
// Sequencer for branch and bit instructions with the internal data RAM.
// Assumes the program bytes are presented on code_i for the address on pc_o.
`timescale 1ns/100ps
module cbbm_core (
    input wire logic clock_i,
    input wire logic rstn_i,
    input wire logic [7:0] code_i,
    input wire logic [7:0] acc_i,
    input wire logic [15:0] data_pointer_16_i,
    input wire logic [7:0] program_status_word_i,
    input wire logic [7:0] program_store_control_i,
    input wire logic [7:0] special_function_register_rdata_i,
    input wire logic ext_write_i,
    input wire logic [15:0] ext_write_addr_i,
    input wire logic [7:0] ext_write_data_i,
    input wire logic [15:0] ret_addr_i,
    output logic [15:0] pc_o,
    output logic carry_o,
    output logic busy_o,
    output logic [2:0] cycles_o,
    output logic [7:0] special_function_register_addr_o,
    output logic special_function_register_we_o,
    output logic [7:0] special_function_register_wdata_o,
    output logic [15:0] call_push_o,
    output logic call_push_o_valid_o,
    output logic store_we_o,
    output logic [15:0] store_addr_o,
    output logic [7:0] store_data_o,
    output logic reserved_fetch_o
);
    import cbbm_pkg::*;

    // ********************************
    // State
    // ********************************
    typedef enum logic [3:0] {
        CBBM_S_FETCH = 4'b0001,
        CBBM_S_OPND = 4'b0010,
        CBBM_S_WAIT = 4'b1000
    } cbbm_state_t;

    cbbm_state_t state_ff, nxt_state;
    logic [15:0] pc_ff, nxt_pc;
    logic [7:0] op_hold_ff, nxt_op;
    logic [7:0] b1_ff, nxt_b1;
    logic [1:0] idx_ff, nxt_idx;
    logic [2:0] cnt_ff, nxt_cnt;
    logic carry_ff, nxt_carry;
    logic [7:0] ram [0:255]; // (RQ18)
    logic ram_we;
    logic [7:0] ram_wa, ram_wd;
    logic sfr_we_ff, nxt_sfr_we;
    logic [7:0] sfr_wa_ff, sfr_wd_ff;
    logic push_ff, nxt_push;
    logic [15:0] push_addr_ff;
    logic st_we_ff;
    logic [15:0] st_a_ff;
    logic [7:0] st_d_ff;
    logic rsv_ff;
    logic [2:0] cyc_ff;

    cbbm_dec_t dec, dec_reg;
    cbbm_daddr_t da;
    logic [2:0] bitpos;

    // Current opcode and first operand, live on the byte that carries them, held after that
    wire in_fetch = (state_ff == CBBM_S_FETCH);
    wire [7:0] op_ff = in_fetch ? code_i : op_hold_ff;
    wire [7:0] byte1 = (idx_ff == 2'd1) ? code_i : b1_ff;
    wire [15:0] pc_next = pc_ff + 16'h0001;

    // ********************************
    // Decode and routing
    // ********************************
    cbbm_decode u_decode (
        .opcode_i(op_ff),
        .dec_o(dec)
    );
    assign dec_reg = dec; // (RQ10)

    wire [1:0] bank = {program_status_word_i[CBBM_PSW_BANK_HI_POS],
                       program_status_word_i[CBBM_PSW_BANK_LO_POS]}; // (RQ20)
    wire is_rn_op = (op_ff[7:3] == CBBM_OPC_CJNE_RN_HI) || (op_ff[7:3] == CBBM_OPC_DJNZ_RN_HI);
    wire is_ind_op = (op_ff[7:1] == 7'h5b);
    wire is_bit_op = dec_reg.act != CBBM_ACT_NONE && dec_reg.bytes == 2'd2
                     || op_ff == CBBM_OPC_JB || op_ff == CBBM_OPC_JNB || op_ff == CBBM_OPC_JBC;
    wire [7:0] ptr = ram[{3'b000, bank, 2'b00, op_ff[0]}]; // (RQ12)

    cbbm_memmap u_memmap (
        .operand_i(byte1),
        .indirect_i(is_ind_op),
        .bit_op_i(is_bit_op),
        .reg_op_i(is_rn_op),
        .reg_sel_i(op_ff[2:0]),
        .ptr_i(ptr),
        .bank_i(bank),
        .addr_o(da),
        .bitpos_o(bitpos)
    );

    wire [7:0] byte_rd = da.to_sfr ? special_function_register_rdata_i : ram[da.ram_addr];
    wire bit_val = byte_rd[bitpos];
    // Offset relative to next instruction
    wire [7:0] rel = code_i;
    wire [15:0] rel_tgt = pc_next + {{8{rel[7]}}, rel}; // (RQ11)
    wire [15:0] abs_tgt = (pc_next & CBBM_PAGE_MASK) | {5'h00, op_ff[7:5], byte1}; // (RQ14)
    wire [15:0] long_tgt = {b1_ff, code_i}; // (RQ15)
    wire [7:0] cmp_l = (op_ff == CBBM_OPC_CJNE_DIR || op_ff == CBBM_OPC_CJNE_IMM) ? acc_i : byte_rd;
    wire [7:0] cmp_r = (op_ff == CBBM_OPC_CJNE_DIR) ? byte_rd : byte1;
    wire [7:0] dec_val = byte_rd - 8'h01;

    logic take;
    logic [15:0] tgt;
    always_comb begin
        take = 1'b0;
        tgt = rel_tgt;
        if (op_ff == CBBM_OPC_JC) take = carry_ff;
        else if (op_ff == CBBM_OPC_JNC) take = !carry_ff;
        else if (op_ff == CBBM_OPC_JB || op_ff == CBBM_OPC_JBC) take = bit_val;
        else if (op_ff == CBBM_OPC_JNB) take = !bit_val;
        else if (op_ff == CBBM_OPC_JZ) take = (acc_i == 8'h00);
        else if (op_ff == CBBM_OPC_JNZ) take = (acc_i != 8'h00);
        else if (dec_reg.bytes == 2'd3 && dec_reg.cond && op_ff[7:4] == 4'hb)
            take = (cmp_l != cmp_r); // (RQ8)
        else if (op_ff[7:4] == 4'hd && dec_reg.cond) take = (dec_val != 8'h00); // (RQ9)
        else if (op_ff[4:0] == CBBM_OPC_AJMP_LOW || op_ff[4:0] == CBBM_OPC_ACALL_LOW) begin
            take = 1'b1;
            tgt = abs_tgt;
        end else if (op_ff == CBBM_OPC_LJMP || op_ff == CBBM_OPC_LCALL) begin
            take = 1'b1;
            tgt = long_tgt;
        end else if (op_ff == CBBM_OPC_SJMP) take = 1'b1;
        else if (op_ff == CBBM_OPC_JMP_ADPTR) begin
            take = 1'b1;
            tgt = data_pointer_16_i + {8'h00, acc_i};
        end else if (op_ff == CBBM_OPC_RET || op_ff == CBBM_OPC_RETI) begin
            take = 1'b1;
            tgt = ret_addr_i;
        end
    end

    // Carry and bit result
    logic c_new, b_new, b_wr;
    always_comb begin
        c_new = carry_ff;
        b_new = bit_val;
        b_wr = 1'b0;
        case (dec_reg.act)
            CBBM_ACT_CLR: if (dec_reg.bytes == 2'd1) c_new = 1'b0;
                          else if (!dec_reg.cond || bit_val) begin
                              b_new = 1'b0; // (RQ3)
                              b_wr = 1'b1;
                          end
            CBBM_ACT_SET: if (dec_reg.bytes == 2'd1) c_new = 1'b1;
                          else begin b_new = 1'b1; b_wr = 1'b1; end
            CBBM_ACT_CPL: if (dec_reg.bytes == 2'd1) c_new = !carry_ff;
                          else begin b_new = !bit_val; b_wr = 1'b1; end
            CBBM_ACT_ANL: c_new = carry_ff & bit_val; // (RQ1)
            CBBM_ACT_ANLN: c_new = carry_ff & !bit_val;
            CBBM_ACT_ORL: c_new = carry_ff | bit_val;
            CBBM_ACT_ORLN: c_new = carry_ff | !bit_val;
            CBBM_ACT_MOVC: c_new = bit_val;
            CBBM_ACT_MOVB: begin b_new = carry_ff; b_wr = 1'b1; end
            default: c_new = carry_ff;
        endcase
    end

    wire [7:0] bit_byte_new = (byte_rd & ~(8'h01 << bitpos)) | ({7'h00, b_new} << bitpos);
    wire wr_djnz = op_ff[7:4] == 4'hd && dec_reg.cond;
    // Executes on the cycle of its last byte
    wire do_exec = in_fetch ? (dec.bytes == 2'd1)
                            : (state_ff == CBBM_S_OPND) && (idx_ff + 2'd1 == dec.bytes);
    assign ram_we = do_exec && !da.to_sfr && (b_wr || wr_djnz);
    assign ram_wa = da.ram_addr;
    assign ram_wd = wr_djnz ? dec_val : bit_byte_new;
    wire is_call = op_ff[4:0] == CBBM_OPC_ACALL_LOW || op_ff == CBBM_OPC_LCALL;
    // Store writes only while enabled
    wire st_en = ext_write_i && program_store_control_i[CBBM_STORE_WREN_POS]; // (RQ17)
    wire [2:0] cyc_used = take ? dec_reg.cyc_long : dec_reg.cyc_short; // (RQ23)

    // ********************************
    // Sequencer
    // ********************************
    always_comb begin
        nxt_state = state_ff;
        nxt_pc = pc_ff;
        nxt_op = op_ff;
        nxt_b1 = b1_ff;
        nxt_idx = idx_ff;
        nxt_cnt = cnt_ff;
        nxt_carry = carry_ff;
        nxt_sfr_we = 1'b0;
        nxt_push = 1'b0;
        case (state_ff)
            CBBM_S_FETCH: begin
                nxt_op = code_i;
                nxt_pc = pc_next;
                nxt_idx = 2'd1;
                nxt_state = CBBM_S_OPND;
            end
            CBBM_S_OPND: begin
                if (idx_ff == 2'd1) nxt_b1 = code_i;
                nxt_pc = pc_next;
                nxt_idx = idx_ff + 2'd1;
            end
            CBBM_S_WAIT: begin
                nxt_cnt = cnt_ff - 3'd1;
                if (cnt_ff <= 3'd1) nxt_state = CBBM_S_FETCH;
            end
            default: nxt_state = CBBM_S_FETCH;
        endcase
        // Clocks beyond the byte count are spent waiting
        if (do_exec) begin
            nxt_carry = c_new;
            nxt_sfr_we = da.to_sfr && b_wr;
            nxt_push = is_call;
            if (take) nxt_pc = tgt;
            nxt_cnt = cyc_used - {1'b0, dec_reg.bytes};
            nxt_idx = 2'd0;
            nxt_state = (cyc_used > {1'b0, dec_reg.bytes}) ? CBBM_S_WAIT : CBBM_S_FETCH;
        end
    end

    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_ff <= CBBM_S_FETCH;
            pc_ff <= CBBM_PC_RESET;
            op_hold_ff <= 8'h00;
            b1_ff <= 8'h00;
            idx_ff <= 2'd0;
            cnt_ff <= 3'd0;
            carry_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            pc_ff <= nxt_pc;
            op_hold_ff <= nxt_op;
            b1_ff <= nxt_b1;
            idx_ff <= nxt_idx;
            cnt_ff <= nxt_cnt;
            carry_ff <= nxt_carry;
        end
    end

    always_ff @(posedge clock_i) begin
        if (ram_we) ram[ram_wa] <= ram_wd;
    end

    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sfr_we_ff <= 1'b0;
            sfr_wa_ff <= 8'h00;
            sfr_wd_ff <= 8'h00;
            push_ff <= 1'b0;
            push_addr_ff <= 16'h0000;
            st_we_ff <= 1'b0;
            st_a_ff <= 16'h0000;
            st_d_ff <= 8'h00;
            rsv_ff <= 1'b0;
            cyc_ff <= 3'd0;
        end else begin
            sfr_we_ff <= nxt_sfr_we;
            sfr_wa_ff <= da.sfr_addr;
            sfr_wd_ff <= wr_djnz ? dec_val : bit_byte_new;
            push_ff <= nxt_push;
            push_addr_ff <= pc_next;
            st_we_ff <= st_en;
            st_a_ff <= ext_write_addr_i;
            st_d_ff <= ext_write_data_i;
            rsv_ff <= pc_ff > CBBM_RESERVED_ABOVE; // (RQ16)
            if (do_exec) cyc_ff <= cyc_used;
        end
    end

    // ********************************
    // Outputs
    // ********************************
    assign pc_o = pc_ff;
    assign carry_o = carry_ff;
    assign busy_o = (state_ff != CBBM_S_FETCH);
    assign cycles_o = cyc_ff;
    assign special_function_register_addr_o = sfr_wa_ff;
    assign special_function_register_we_o = sfr_we_ff;
    assign special_function_register_wdata_o = sfr_wd_ff;
    assign call_push_o = push_addr_ff;
    assign call_push_o_valid_o = push_ff;
    assign store_we_o = st_we_ff;
    assign store_addr_o = st_a_ff;
    assign store_data_o = st_d_ff;
    assign reserved_fetch_o = rsv_ff;

endmodule // cbbm_core

// ---- cbbm_core_checker.sv ----
// Port checker for the branch, bit and memory-map sequencer.
// Assumes binding into cbbm_core; one clock, async active-low reset.
`timescale 1ns/100ps
module cbbm_core_checker (
    input wire logic clock_i,
    input wire logic rstn_i,
    input wire logic [7:0] code_i,
    input wire logic [7:0] program_store_control_i,
    input wire logic ext_write_i,
    input wire logic [15:0] ext_write_addr_i,
    input wire logic [15:0] ret_addr_i,
    input wire logic [15:0] pc_o,
    input wire logic carry_o,
    input wire logic busy_o,
    input wire logic [2:0] cycles_o,
    input wire logic store_we_o,
    input wire logic [15:0] store_addr_o,
    input wire logic reserved_fetch_o
);
    wire logic [15:0] rel_ext = {{8{code_i[7]}}, code_i};
    wire logic pc_high = pc_o > 16'h3dff;
    default clocking @(posedge clock_i); endclocking
    default disable iff (!rstn_i);
    property p_nop;
        !busy_o && (code_i == 8'h00 || code_i == 8'ha5)
            |=> !busy_o && pc_o == $past(pc_o) + 16'h0001;
    endproperty
    a_nop: assert property (p_nop) else $error("no-op not one clock");
    property p_setc; !busy_o && code_i == 8'hd3 |=> !busy_o && carry_o; endproperty
    a_setc: assert property (p_setc) else $error("carry set wrong");
    property p_ljmp;
        !busy_o && code_i == 8'h02 |=> busy_o [*3] ##1 (!busy_o && cycles_o == 3'd4);
    endproperty
    a_ljmp: assert property (p_ljmp) else $error("long jump length");
    property p_ret;
        !busy_o && (code_i == 8'h22 || code_i == 8'h32)
            |=> busy_o [*4] ##1 (!busy_o && pc_o == ret_addr_i);
    endproperty
    a_ret: assert property (p_ret) else $error("return length or target");
    property p_sjmp;
        !busy_o && code_i == 8'h80
            |-> ##3 (!busy_o && pc_o == $past(pc_o, 2) + 16'h0001 + $past(rel_ext, 2));
    endproperty
    a_sjmp: assert property (p_sjmp) else $error("short jump target");
    property p_drop; ext_write_i && !program_store_control_i[0] |=> !store_we_o; endproperty
    a_drop: assert property (p_drop) else $error("store write not dropped");
    property p_copy;
        ext_write_i && program_store_control_i[0]
            |=> store_we_o && store_addr_o == $past(ext_write_addr_i);
    endproperty
    a_copy: assert property (p_copy) else $error("store write lost");
    property p_rsv; $past(pc_high) == pc_high |-> reserved_fetch_o == pc_high; endproperty
    a_rsv: assert property (p_rsv) else $error("reserved fetch flag");
endmodule // cbbm_core_checker

bind cbbm_core cbbm_core_checker u_checker (.*);

// ---- cbbm_decode.sv ----
// Opcode decoder: length, cycle counts, carry/bit action of each branch or bit opcode.
// Assumes a purely combinational use inside the sequencer.
`timescale 1ns/100ps
module cbbm_decode (
    input wire logic [7:0] opcode_i,
    output cbbm_pkg::cbbm_dec_t dec_o
);
    import cbbm_pkg::*;

    wire [4:0] hi5 = opcode_i[7:3];
    wire [4:0] lo5 = opcode_i[4:0];

    function automatic cbbm_dec_t mk(input logic [1:0] b, input logic [2:0] s,
                                     input logic [2:0] l, input cbbm_act_t a);
        cbbm_dec_t d;
        d.known = 1'b1;
        d.bytes = b;
        d.cyc_short = s;
        d.cyc_long = l;
        d.cond = (s != l);
        d.on_carry = 1'b0;
        d.act = a;
        return d;
    endfunction

    always_comb begin
        dec_o = mk(2'd1, 3'd1, 3'd1, CBBM_ACT_NONE);
        dec_o.known = 1'b0;
        if (opcode_i == CBBM_OPC_CLR_C) dec_o = mk(2'd1, 3'd1, 3'd1, CBBM_ACT_CLR); // (RQ1)
        else if (opcode_i == CBBM_OPC_SETB_C) dec_o = mk(2'd1, 3'd1, 3'd1, CBBM_ACT_SET);
        else if (opcode_i == CBBM_OPC_CPL_C) dec_o = mk(2'd1, 3'd1, 3'd1, CBBM_ACT_CPL);
        else if (opcode_i == CBBM_OPC_CLR_BIT) dec_o = mk(2'd2, 3'd2, 3'd2, CBBM_ACT_CLR);
        else if (opcode_i == CBBM_OPC_SETB_BIT) dec_o = mk(2'd2, 3'd2, 3'd2, CBBM_ACT_SET);
        else if (opcode_i == CBBM_OPC_CPL_BIT) dec_o = mk(2'd2, 3'd2, 3'd2, CBBM_ACT_CPL);
        else if (opcode_i == CBBM_OPC_ANL_C) dec_o = mk(2'd2, 3'd2, 3'd2, CBBM_ACT_ANL);
        else if (opcode_i == CBBM_OPC_ANL_CN) dec_o = mk(2'd2, 3'd2, 3'd2, CBBM_ACT_ANLN);
        else if (opcode_i == CBBM_OPC_ORL_C) dec_o = mk(2'd2, 3'd2, 3'd2, CBBM_ACT_ORL);
        else if (opcode_i == CBBM_OPC_ORL_CN) dec_o = mk(2'd2, 3'd2, 3'd2, CBBM_ACT_ORLN);
        else if (opcode_i == CBBM_OPC_MOV_C_BIT) dec_o = mk(2'd2, 3'd2, 3'd2, CBBM_ACT_MOVC);
        else if (opcode_i == CBBM_OPC_MOV_BIT_C) dec_o = mk(2'd2, 3'd2, 3'd2, CBBM_ACT_MOVB);
        else if (opcode_i == CBBM_OPC_JC || opcode_i == CBBM_OPC_JNC)
            dec_o = mk(2'd2, 3'd2, 3'd3, CBBM_ACT_NONE); // (RQ2)
        else if (opcode_i == CBBM_OPC_JB || opcode_i == CBBM_OPC_JNB)
            dec_o = mk(2'd3, 3'd3, 3'd4, CBBM_ACT_NONE); // (RQ3)
        else if (opcode_i == CBBM_OPC_JBC) dec_o = mk(2'd3, 3'd3, 3'd4, CBBM_ACT_CLR);
        else if (lo5 == CBBM_OPC_ACALL_LOW) dec_o = mk(2'd2, 3'd3, 3'd3, CBBM_ACT_NONE); // (RQ4)
        else if (opcode_i == CBBM_OPC_LCALL) dec_o = mk(2'd3, 3'd4, 3'd4, CBBM_ACT_NONE);
        else if (opcode_i == CBBM_OPC_RET || opcode_i == CBBM_OPC_RETI)
            dec_o = mk(2'd1, 3'd5, 3'd5, CBBM_ACT_NONE); // (RQ5)
        else if (lo5 == CBBM_OPC_AJMP_LOW || opcode_i == CBBM_OPC_SJMP)
            dec_o = mk(2'd2, 3'd3, 3'd3, CBBM_ACT_NONE); // (RQ6)
        else if (opcode_i == CBBM_OPC_LJMP) dec_o = mk(2'd3, 3'd4, 3'd4, CBBM_ACT_NONE);
        else if (opcode_i == CBBM_OPC_JMP_ADPTR) dec_o = mk(2'd1, 3'd3, 3'd3, CBBM_ACT_NONE);
        else if (opcode_i == CBBM_OPC_JZ || opcode_i == CBBM_OPC_JNZ)
            dec_o = mk(2'd2, 3'd2, 3'd3, CBBM_ACT_NONE); // (RQ7)
        else if (opcode_i == CBBM_OPC_CJNE_DIR || opcode_i == CBBM_OPC_CJNE_IMM
                 || hi5 == CBBM_OPC_CJNE_RN_HI)
            dec_o = mk(2'd3, 3'd3, 3'd4, CBBM_ACT_NONE); // (RQ8)
        else if (hi5 == CBBM_OPC_CJNE_IND_HI && opcode_i[2:1] == 2'b11)
            dec_o = mk(2'd3, 3'd4, 3'd5, CBBM_ACT_NONE); // (RQ8)
        else if (hi5 == CBBM_OPC_DJNZ_RN_HI) dec_o = mk(2'd2, 3'd2, 3'd3, CBBM_ACT_NONE); // (RQ9)
        else if (opcode_i == CBBM_OPC_DJNZ_DIR) dec_o = mk(2'd3, 3'd3, 3'd4, CBBM_ACT_NONE);
        else if (opcode_i == CBBM_OPC_NOP || opcode_i == CBBM_OPC_SPARE)
            dec_o = mk(2'd1, 3'd1, 3'd1, CBBM_ACT_NONE); // (RQ10)
        dec_o.on_carry = (opcode_i == CBBM_OPC_JC) || (opcode_i == CBBM_OPC_JNC);
    end

endmodule // cbbm_decode

// ---- cbbm_memmap.sv ----
// Data memory address router: banks, bit area, lower/upper RAM and special registers.
// Assumes operands already fetched; purely combinational.
`timescale 1ns/100ps
module cbbm_memmap (
    input wire logic [7:0] operand_i,
    input wire logic indirect_i,
    input wire logic bit_op_i,
    input wire logic reg_op_i,
    input wire logic [2:0] reg_sel_i,
    input wire logic [7:0] ptr_i,
    input wire logic [1:0] bank_i,
    output cbbm_pkg::cbbm_daddr_t addr_o,
    output logic [2:0] bitpos_o
);
    import cbbm_pkg::*;

    // Byte behind a bit address
    wire [7:0] bit_byte = operand_i[7] ? {operand_i[7:3], 3'b000}
                                       : CBBM_BIT_BYTE_BASE + {4'h0, operand_i[6:3]}; // (RQ21)
    wire [7:0] reg_addr = {3'b000, bank_i, reg_sel_i}; // (RQ20)
    wire [7:0] raw = reg_op_i ? reg_addr : indirect_i ? ptr_i : bit_op_i ? bit_byte : operand_i;
    // Bit vs byte chosen only by instruction kind
    assign bitpos_o = bit_op_i ? operand_i[2:0] : 3'd0; // (RQ22)
    assign addr_o.ram_addr = raw;
    // Direct high addresses go to special registers, indirect ones to upper RAM
    assign addr_o.to_sfr = !indirect_i && !reg_op_i && (raw > CBBM_LOW_RAM_TOP); // (RQ13) (RQ19)
    assign addr_o.sfr_addr = raw;
    assign addr_o.is_bank = (raw <= CBBM_BANK_TOP);

endmodule // cbbm_memmap

// ---- cbbm_pkg.sv ----
// Package for the branch, bit and memory-map block of the 8-bit core.
// Assumes one clock and an asynchronous active-low reset.
package cbbm_pkg;

    // ********************************
    // Memory map
    // ********************************
    localparam logic [7:0] CBBM_LOW_RAM_TOP = 8'h7f;
    localparam logic [7:0] CBBM_BANK_TOP = 8'h1f;
    localparam logic [7:0] CBBM_BIT_BYTE_BASE = 8'h20;
    localparam logic [7:0] CBBM_BIT_ADDR_TOP = 8'h7f;
    localparam logic [15:0] CBBM_FLASH_TOP = 16'h3fff;
    localparam logic [15:0] CBBM_RESERVED_ABOVE = 16'h3dff;
    localparam logic [15:0] CBBM_PAGE_MASK = 16'hf800;
    localparam int CBBM_PSW_BANK_LO_POS = 3;
    localparam int CBBM_PSW_BANK_HI_POS = 4;
    localparam int CBBM_PSW_CARRY_POS = 7;
    localparam int CBBM_STORE_WREN_POS = 0;
    localparam logic [15:0] CBBM_PC_RESET = 16'h0000;
    localparam logic [7:0] CBBM_OPC_NOP = 8'h00;
    localparam logic [7:0] CBBM_OPC_SPARE = 8'ha5;

    // ********************************
    // Opcodes handled here
    // ********************************
    localparam logic [7:0] CBBM_OPC_CLR_C = 8'hc3;
    localparam logic [7:0] CBBM_OPC_SETB_C = 8'hd3;
    localparam logic [7:0] CBBM_OPC_CPL_C = 8'hb3;
    localparam logic [7:0] CBBM_OPC_CLR_BIT = 8'hc2;
    localparam logic [7:0] CBBM_OPC_SETB_BIT = 8'hd2;
    localparam logic [7:0] CBBM_OPC_CPL_BIT = 8'hb2;
    localparam logic [7:0] CBBM_OPC_ANL_C = 8'h82;
    localparam logic [7:0] CBBM_OPC_ANL_CN = 8'hb0;
    localparam logic [7:0] CBBM_OPC_ORL_C = 8'h72;
    localparam logic [7:0] CBBM_OPC_ORL_CN = 8'ha0;
    localparam logic [7:0] CBBM_OPC_MOV_C_BIT = 8'ha2;
    localparam logic [7:0] CBBM_OPC_MOV_BIT_C = 8'h92;
    localparam logic [7:0] CBBM_OPC_JC = 8'h40;
    localparam logic [7:0] CBBM_OPC_JNC = 8'h50;
    localparam logic [7:0] CBBM_OPC_JB = 8'h20;
    localparam logic [7:0] CBBM_OPC_JNB = 8'h30;
    localparam logic [7:0] CBBM_OPC_JBC = 8'h10;
    localparam logic [7:0] CBBM_OPC_LCALL = 8'h12;
    localparam logic [7:0] CBBM_OPC_RET = 8'h22;
    localparam logic [7:0] CBBM_OPC_RETI = 8'h32;
    localparam logic [7:0] CBBM_OPC_LJMP = 8'h02;
    localparam logic [7:0] CBBM_OPC_SJMP = 8'h80;
    localparam logic [7:0] CBBM_OPC_JMP_ADPTR = 8'h73;
    localparam logic [7:0] CBBM_OPC_JZ = 8'h60;
    localparam logic [7:0] CBBM_OPC_JNZ = 8'h70;
    localparam logic [7:0] CBBM_OPC_CJNE_DIR = 8'hb5;
    localparam logic [7:0] CBBM_OPC_CJNE_IMM = 8'hb4;
    localparam logic [7:0] CBBM_OPC_DJNZ_DIR = 8'hd5;
    localparam logic [4:0] CBBM_OPC_AJMP_LOW = 5'h01;
    localparam logic [4:0] CBBM_OPC_ACALL_LOW = 5'h11;
    localparam logic [4:0] CBBM_OPC_CJNE_IND_HI = 5'h16;
    localparam logic [4:0] CBBM_OPC_CJNE_RN_HI = 5'h17;
    localparam logic [4:0] CBBM_OPC_DJNZ_RN_HI = 5'h1b;

    // ********************************
    // Carried types
    // ********************************
    typedef enum logic [3:0] {
        CBBM_ACT_NONE = 4'h0, CBBM_ACT_CLR = 4'h1, CBBM_ACT_SET = 4'h2,
        CBBM_ACT_CPL = 4'h3, CBBM_ACT_ANL = 4'h4, CBBM_ACT_ANLN = 4'h5,
        CBBM_ACT_ORL = 4'h6, CBBM_ACT_ORLN = 4'h7, CBBM_ACT_MOVC = 4'h8,
        CBBM_ACT_MOVB = 4'h9
    } cbbm_act_t;

    typedef struct packed {
        logic known;
        logic [1:0] bytes;
        logic [2:0] cyc_short;
        logic [2:0] cyc_long;
        logic cond;
        logic on_carry;
        cbbm_act_t act;
    } cbbm_dec_t;

    typedef struct packed {
        logic to_sfr;
        logic is_bank;
        logic [7:0] ram_addr;
        logic [7:0] sfr_addr;
    } cbbm_daddr_t;

endpackage

// ---- test_core_branch_bit_and_memory_map.sv ----
// Self-checking bench for the branch, bit and memory-map sequencer.
// Assumes a zero-filled program store read at pc_o in the same cycle.
`timescale 1ns/100ps
module test_core_branch_bit_and_memory_map;
    import cbbm_pkg::*;
    logic clock_i = 1'b0, rstn_i = 1'b0, ext_write_i = 1'b0;
    logic [7:0] acc_i = 8'h00, program_store_control_i = 8'h00, ext_write_data_i = 8'h00;
    logic [7:0] special_function_register_rdata_i = 8'h00, program_status_word_i = 8'h00;
    logic [15:0] ext_write_addr_i = 16'h0000, data_pointer_16_i = 16'h2000;
    logic [15:0] ret_addr_i = 16'h0456, pc_o, call_push_o, store_addr_o;
    logic carry_o, busy_o, call_push_o_valid_o, store_we_o, reserved_fetch_o;
    logic special_function_register_we_o;
    logic [2:0] cycles_o;
    logic [7:0] special_function_register_addr_o, special_function_register_wdata_o, store_data_o;
    logic [7:0] prog [65536];
    wire logic [7:0] code_i = prog[pc_o];
    int mismatches = 0, tests_run = 0;
    logic [7:0] bit_seq [14] = '{8'hd3, 8'h92, 8'h13, 8'hc3, 8'ha2, 8'h13, 8'h10, 8'h13,
        8'h02, 8'h00, 8'h00, 8'h20, 8'h13, 8'h05};
    // Opcode, operands, acc, special byte, clocks, pc after
    logic [63:0] rows [] = '{64'h0000_0000_0001_0001, 64'ha500_0000_0001_0001,
        64'hc300_0000_0001_0001, 64'hd300_0000_0001_0001, 64'hb300_0000_0001_0001,
        64'hc230_0000_0002_0002, 64'hd230_0000_0002_0002, 64'hb230_0000_0002_0002,
        64'h8230_0000_0002_0002, 64'hb030_0000_0002_0002, 64'h7230_0000_0002_0002,
        64'ha030_0000_0002_0002, 64'ha230_0000_0002_0002, 64'h9230_0000_0002_0002,
        64'h4010_0000_0002_0002, 64'h5010_0000_0003_0012, 64'h50fe_0000_0003_0000,
        64'h6005_0000_0003_0007, 64'h7005_0000_0002_0002, 64'h2080_0400_ff04_0007,
        64'h3080_0400_ff03_0003, 64'h1080_0400_ff04_0007, 64'h3123_0000_0003_0123,
        64'h1212_3400_0004_1234, 64'h2200_0000_0005_0456, 64'h3200_0000_0005_0456,
        64'he155_0000_0003_0755, 64'h023a_bc00_0004_3abc, 64'h023e_0000_0004_3e00,
        64'h8080_0000_0003_ff82, 64'h7300_0010_0003_2010, 64'hb405_1000_0004_0013,
        64'hb405_1005_0003_0003, 64'hb580_10ff_ff03_0003, 64'hd580_1000_0103_0003,
        64'hd580_1000_0504_0013};
    cbbm_core dut (.*);
    always #2 clock_i = ~clock_i;
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic restart();
        rstn_i <= 1'b0;
        repeat (4) @(posedge clock_i);
        rstn_i <= 1'b1;
    endtask
    initial begin
        logic [63:0] r;
        foreach (prog[i]) prog[i] = 8'h00;
        repeat (4) @(posedge clock_i);
        #1 check("pc", pc_o, CBBM_PC_RESET);
        foreach (rows[i]) begin
            r = rows[i];
            {prog[0], prog[1], prog[2]} = r[63:40];
            acc_i <= r[39:32];
            special_function_register_rdata_i <= r[31:24];
            restart();
            repeat (r[23:16]) @(posedge clock_i);
            #1 check("pc", pc_o, r[15:0]);
            check("cycles", 16'(cycles_o), 16'(r[23:16]));
            check("rsv", 16'(reserved_fetch_o), 16'(r[15:0] > CBBM_RESERVED_ABOVE));
        end
        foreach (bit_seq[i]) prog[i] = bit_seq[i];
        restart();
        repeat (4) @(posedge clock_i);
        #1 check("carry", 16'(carry_o), 16'h0000);
        repeat (2) @(posedge clock_i);
        #1 check("carry", 16'(carry_o), 16'h0001);
        repeat (7) @(posedge clock_i);
        #1 check("pc", pc_o, 16'h000e);
        for (int en = 0; en < 2; en++) begin
            @(posedge clock_i);
            ext_write_addr_i <= 16'h3a5c;
            ext_write_data_i <= 8'h96;
            program_store_control_i <= 8'(en);
            ext_write_i <= 1'b1;
            @(posedge clock_i);
            ext_write_i <= 1'b0;
            #1 check("store_we", 16'(store_we_o), 16'(en));
            if (en == 1) check("store_data", 16'(store_data_o), 16'h0096);
        end
        complete_run();
    end
    initial begin
        repeat (3000) @(posedge clock_i);
        mismatches++;
        complete_run();
    end
endmodule // test_core_branch_bit_and_memory_map
